//--- logic/pws_cfg.svh
// Constants of the pager wake scheduler
`ifndef PWS_CFG_SVH
`define PWS_CFG_SVH

`define PWS_CLK_MHZ         40
`define PWS_SHORT_BATCH_US  739200
`define PWS_LAST_BATCH_US   912000
`define PWS_HOLD_US         12000000
`define PWS_LAST_CYCLE      6'h3B
`define PWS_LAST_SUBSEQ     3'h4
`define PWS_LAST_BATCH      4'hF
`define PWS_MAX_LEN         3'h5

`define PWS_OFF_CTRL        12'h000
`define PWS_OFF_ADDR        12'h004
`define PWS_OFF_POS         12'h008
`define PWS_OFF_STAT        12'h00C
`define PWS_OFF_EVENT       12'h010
`define PWS_OFF_RXADDR      12'h014

`define PWS_RST_HOME_LEN    3'h0
`define PWS_RST_FRGN_LEN    3'h2
`define PWS_RST_MASK        5'h1F

`define PWS_CTRL_HOME_LSB   0
`define PWS_CTRL_FRGN_LSB   4
`define PWS_CTRL_MASK_LSB   8
`define PWS_CTRL_SLOT_LSB   16
`define PWS_CTRL_FRGN_BIT   24
`define PWS_CTRL_EN_BIT     25
`define PWS_POS_SUB_LSB     8
`define PWS_POS_BAT_LSB     16
`define PWS_EV_NOMSG_BIT    0
`define PWS_EV_OWN_BIT      1
`define PWS_EV_LOWER_BIT    2
`define PWS_EV_RESYNC_BIT   3
`define PWS_STAT_LEN_LSB    5
`define PWS_STAT_DONE_BIT   8
`define PWS_STAT_WAKES_LSB  16

`endif

//--- logic/pws_pkg.sv
// Types of the pager wake scheduler
`default_nettype none
package pws_pkg;
	typedef struct packed {
		logic       enable;
		logic       foreign_net;
		logic [3:0] batch_slot;
		logic [4:0] subsequence_listen_mask;
		logic [2:0] foreign_cycle_match_len;
		logic [2:0] home_cycle_match_len;
	} pws_ctrl_t;

	typedef struct packed {
		logic [5:0] cycle;
		logic [2:0] subseq;
		logic [3:0] batch;
	} pws_pos_t;

	typedef enum logic [1:0] {
		PWS_SLEEP  = 2'b00,
		PWS_SEARCH = 2'b01,
		PWS_HOLD   = 2'b10
	} pws_state_t;
endpackage : pws_pkg
`default_nettype wire

//--- logic/pws_wake_scheduler.sv
// Wake scheduler top with APB register slave
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "pws_cfg.svh"
`default_nettype none
module pws_wake_scheduler #(
	parameter int SHORT_BATCH_CYC = `PWS_SHORT_BATCH_US * `PWS_CLK_MHZ,
	parameter int LAST_BATCH_CYC  = `PWS_LAST_BATCH_US * `PWS_CLK_MHZ,
	parameter int HOLD_CYC        = `PWS_HOLD_US * `PWS_CLK_MHZ
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	output var  logic        rx_power_on,
	output var  logic        batch_tick
);

	pws_pkg::pws_ctrl_t  ctrl;
	pws_pkg::pws_ctrl_t  next_ctrl;
	logic [17:0]         first_address_word;
	logic [17:0]         next_first_address_word;
	logic [31:0]         next_prdata;
	logic                next_pready;
	logic                next_pslverr;

	pws_pkg::pws_pos_t   pos;
	pws_pkg::pws_pos_t   next_pos;
	logic [28:0]         batch_cnt;
	logic [28:0]         next_batch_cnt;
	logic                next_batch_tick;

	pws_pkg::pws_state_t state;
	pws_pkg::pws_state_t next_state;
	logic [28:0]         hold_cnt;
	logic [28:0]         next_hold_cnt;
	logic                slot_done;
	logic                next_slot_done;
	logic                next_rx_power_on;
	logic [15:0]         wake_cnt;
	logic [15:0]         next_wake_cnt;

	logic [17:0]         rx_addr;
	logic [17:0]         next_rx_addr;
	logic                rx_addr_new;
	logic                next_rx_addr_new;
	logic                addr_own;
	logic                addr_lower;

	logic                access;
	logic                wr;
	logic                wr_rx;
	logic                ev_nomsg;
	logic                ev_own;
	logic                ev_lower;
	logic                ev_resync;
	logic                batch_end;
	logic [2:0]          match_len;
	logic [4:0]          match_mask;
	logic                cycle_hit;
	logic                wake_due;

	// Bus access completes on the second access cycle
	assign access = psel & penable & pready;
	assign wr     = access & pwrite & (paddr == `PWS_OFF_EVENT);
	assign wr_rx  = access & pwrite & (paddr == `PWS_OFF_RXADDR);

	assign ev_nomsg  = wr & pwdata[`PWS_EV_NOMSG_BIT];
	assign ev_own    = wr & pwdata[`PWS_EV_OWN_BIT];
	assign ev_lower  = wr & pwdata[`PWS_EV_LOWER_BIT];
	assign ev_resync = wr & pwdata[`PWS_EV_RESYNC_BIT];

	// Cycle match length and comparison
	always_comb begin
		match_len = ctrl.foreign_net ? ctrl.foreign_cycle_match_len
		                             : ctrl.home_cycle_match_len;
		// Codes above 101 are unused; clamp so they behave as five bits
		if (match_len > `PWS_MAX_LEN) begin
			match_len = `PWS_MAX_LEN;
		end
		match_mask = 5'(~(6'h3F << match_len));
		// Zero length gives an empty mask: every cycle hits
		cycle_hit = ((pos.cycle[4:0] ^ first_address_word[4:0]) & match_mask) == 5'h00;
		wake_due  = ctrl.enable & cycle_hit
		          & ctrl.subsequence_listen_mask[pos.subseq]
		          & (pos.batch == ctrl.batch_slot);
	end

	// Register file
	always_comb begin
		next_ctrl               = ctrl;
		next_first_address_word = first_address_word;
		next_pready             = psel & penable & ~pready;
		next_pslverr            = 1'b0;
		next_prdata             = 32'h0000_0000;
		if (psel & penable & ~pready) begin
			unique case (paddr)
				`PWS_OFF_CTRL: begin
					next_prdata[`PWS_CTRL_HOME_LSB +: 3] = ctrl.home_cycle_match_len;
					next_prdata[`PWS_CTRL_FRGN_LSB +: 3] = ctrl.foreign_cycle_match_len;
					next_prdata[`PWS_CTRL_MASK_LSB +: 5] = ctrl.subsequence_listen_mask;
					next_prdata[`PWS_CTRL_SLOT_LSB +: 4] = ctrl.batch_slot;
					next_prdata[`PWS_CTRL_FRGN_BIT]      = ctrl.foreign_net;
					next_prdata[`PWS_CTRL_EN_BIT]        = ctrl.enable;
				end
				`PWS_OFF_ADDR: begin
					next_prdata[17:0] = first_address_word;
				end
				`PWS_OFF_POS: begin
					next_prdata[5:0]                    = pos.cycle;
					next_prdata[`PWS_POS_SUB_LSB +: 3] = pos.subseq;
					next_prdata[`PWS_POS_BAT_LSB +: 4] = pos.batch;
				end
				`PWS_OFF_STAT: begin
					next_prdata[0]   = rx_power_on;
					next_prdata[2:1] = state;
					next_prdata[3]   = cycle_hit;
					next_prdata[4]   = wake_due;
					next_prdata[`PWS_STAT_LEN_LSB +: 3]    = match_len;
					next_prdata[`PWS_STAT_DONE_BIT]        = slot_done;
					// Wake count wraps at 16 bits; software works on differences
					next_prdata[`PWS_STAT_WAKES_LSB +: 16] = wake_cnt;
				end
				`PWS_OFF_EVENT: begin
					next_prdata = 32'h0000_0000;
				end
				// Write only: each write starts one address compare
				`PWS_OFF_RXADDR: begin
					next_prdata = 32'h0000_0000;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		if (access & pwrite) begin
			if (paddr == `PWS_OFF_CTRL) begin
				next_ctrl.home_cycle_match_len    = pwdata[`PWS_CTRL_HOME_LSB +: 3];
				next_ctrl.foreign_cycle_match_len = pwdata[`PWS_CTRL_FRGN_LSB +: 3];
				next_ctrl.subsequence_listen_mask = pwdata[`PWS_CTRL_MASK_LSB +: 5];
				next_ctrl.batch_slot              = pwdata[`PWS_CTRL_SLOT_LSB +: 4];
				next_ctrl.foreign_net             = pwdata[`PWS_CTRL_FRGN_BIT];
				next_ctrl.enable                  = pwdata[`PWS_CTRL_EN_BIT];
			end
			if (paddr == `PWS_OFF_ADDR) begin
				next_first_address_word = pwdata[17:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl.home_cycle_match_len    <= `PWS_RST_HOME_LEN;
			ctrl.foreign_cycle_match_len <= `PWS_RST_FRGN_LEN;
			ctrl.subsequence_listen_mask <= `PWS_RST_MASK;
			ctrl.batch_slot              <= 4'h0;
			ctrl.foreign_net             <= 1'b0;
			ctrl.enable                  <= 1'b0;
			first_address_word           <= 18'h00000;
			prdata                       <= 32'h0000_0000;
			pready                       <= 1'b0;
			pslverr                      <= 1'b0;
		end else begin
			ctrl               <= next_ctrl;
			first_address_word <= next_first_address_word;
			prdata             <= next_prdata;
			pready             <= next_pready;
			pslverr            <= next_pslverr;
		end
	end

	// Batch timer and position in the sequence
	assign batch_end = (pos.batch == `PWS_LAST_BATCH)
	                 ? (batch_cnt == 29'(LAST_BATCH_CYC - 1))
	                 : (batch_cnt == 29'(SHORT_BATCH_CYC - 1));

	always_comb begin
		next_pos        = pos;
		next_batch_cnt  = batch_cnt + 29'h1;
		next_batch_tick = 1'b0;
		if (ev_resync) begin
			next_pos       = '0;
			next_batch_cnt = 29'h0;
		end else if (batch_end) begin
			next_batch_cnt  = 29'h0;
			next_batch_tick = 1'b1;
			next_pos.batch  = pos.batch + 4'h1;
			if (pos.batch == `PWS_LAST_BATCH) begin
				if (pos.subseq == `PWS_LAST_SUBSEQ) begin
					next_pos.subseq = 3'h0;
					// Sequence wraps after cycle 59
					next_pos.cycle  = (pos.cycle == `PWS_LAST_CYCLE) ? 6'h00 : pos.cycle + 6'h01;
				end else begin
					next_pos.subseq = pos.subseq + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos        <= '0;
			batch_cnt  <= 29'h0;
			batch_tick <= 1'b0;
		end else begin
			pos        <= next_pos;
			batch_cnt  <= next_batch_cnt;
			batch_tick <= next_batch_tick;
		end
	end

	// Software writes each received initial address here while searching
	always_comb begin
		next_rx_addr     = rx_addr;
		next_rx_addr_new = wr_rx;
		if (wr_rx) begin
			next_rx_addr = pwdata[17:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_addr     <= 18'h00000;
			rx_addr_new <= 1'b0;
		end else begin
			rx_addr     <= next_rx_addr;
			rx_addr_new <= next_rx_addr_new;
		end
	end

	// Compared a cycle after the write, keeping the bus decode off this path
	// Addresses arrive in descending order, so a lower one ends the search
	assign addr_own   = rx_addr_new & (rx_addr == first_address_word);
	assign addr_lower = rx_addr_new & (rx_addr < first_address_word);

	// Power sequencing
	always_comb begin
		next_state     = state;
		next_hold_cnt  = hold_cnt;
		next_slot_done = batch_end ? 1'b0 : slot_done;
		next_wake_cnt  = wake_cnt;
		unique case (state)
			pws_pkg::PWS_SLEEP: begin
				// Slot done stops a re-wake after an early power down
				if (wake_due & ~slot_done & ~batch_end) begin
					next_state    = pws_pkg::PWS_SEARCH;
					next_wake_cnt = wake_cnt + 16'h0001;
				end
			end
			pws_pkg::PWS_SEARCH: begin
				// Address compare and software events end the search alike
				if (ev_own | addr_own) begin
					next_state    = pws_pkg::PWS_HOLD;
					next_hold_cnt = 29'(HOLD_CYC - 1);
				end else if (ev_nomsg | ev_lower | addr_lower) begin
					next_state     = pws_pkg::PWS_SLEEP;
					next_slot_done = ~batch_end;
				end else if (batch_end) begin
					next_state = pws_pkg::PWS_SLEEP;
				end
			end
			pws_pkg::PWS_HOLD: begin
				// Hold spans later batches; messages may run over
				if (hold_cnt == 29'h0) begin
					next_state = pws_pkg::PWS_SLEEP;
				end else begin
					next_hold_cnt = hold_cnt - 29'h1;
				end
			end
			default: begin
				next_state = pws_pkg::PWS_SLEEP;
			end
		endcase
		next_rx_power_on = next_state != pws_pkg::PWS_SLEEP;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= pws_pkg::PWS_SLEEP;
			hold_cnt    <= 29'h0;
			slot_done   <= 1'b0;
			rx_power_on <= 1'b0;
			wake_cnt    <= 16'h0000;
		end else begin
			state       <= next_state;
			hold_cnt    <= next_hold_cnt;
			slot_done   <= next_slot_done;
			rx_power_on <= next_rx_power_on;
			wake_cnt    <= next_wake_cnt;
		end
	end

endmodule : pws_wake_scheduler
`default_nettype wire

//--- dv/pws_sva.sv
// Port checker of the wake scheduler
`timescale 1ns/1ps
`default_nettype none
module pws_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        rx_power_on,
	input wire logic        batch_tick
);
	logic en;
	logic next_en;
	always_comb begin
		next_en = en;
		if (psel && penable && pready && pwrite && paddr == 12'h000)
			next_en = pwdata[25];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en <= 1'b0;
		else
			en <= next_en;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
	ready_wait_a: assert property (pready |-> psel && penable && $past(penable)) else $error("pready early");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	unmapped_a: assert property (pready && paddr > 12'h014 |-> pslverr) else $error("no error on hole");
	mapped_a: assert property (pready && paddr <= 12'h014 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped register");
	tick_gap_a: assert property (batch_tick |-> ##1 (!batch_tick)[*8]) else $error("slot too short");
	wake_enable_a: assert property ($rose(rx_power_on) |-> $past(en)) else $error("wake while off");
	wake_stands_a: assert property ($rose(rx_power_on) |-> rx_power_on[*3]) else $error("wake dropped");
endmodule : pws_sva
bind pws_wake_scheduler pws_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rx_power_on(rx_power_on), .batch_tick(batch_tick));
`default_nettype wire

//--- dv/pws_tx_model.sv
// Transmitter timing model: batch position on air
`timescale 1ns/1ps
`default_nettype none
module pws_tx_model (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              sync,
	input  wire logic              batch_tick,
	output var  pws_pkg::pws_pos_t pos
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pos <= '0;
		else if (sync)
			pos <= '0;
		else if (batch_tick) begin
			pos.batch <= pos.batch + 4'h1;
			if (pos.batch == 4'hF) begin
				pos.subseq <= (pos.subseq == 3'h4) ? 3'h0 : pos.subseq + 3'h1;
				if (pos.subseq == 3'h4)
					pos.cycle <= (pos.cycle == 6'h3B) ? 6'h00 : pos.cycle + 6'h01;
			end
		end
	end
endmodule : pws_tx_model
`default_nettype wire

//--- dv/pws_wake_scheduler_tb_top.sv
// Self-checking bench of the wake scheduler
`timescale 1ns/1ps
`default_nettype none
module pws_wake_scheduler_tb_top;
	localparam int SHORT_CYC = 20;
	localparam int LAST_CYC  = 26;
	localparam int CYCLE_CLK = 5 * (15 * SHORT_CYC + LAST_CYC);
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [11:0]       paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              rx_power_on;
	logic              batch_tick;
	logic              sync;
	pws_pkg::pws_pos_t pos;
	logic [31:0]       rd;
	logic              er;
	int                miscompares = 0;
	int                n_checks = 0;
	int                cyc = 0;
	pws_wake_scheduler #(.SHORT_BATCH_CYC(SHORT_CYC), .LAST_BATCH_CYC(LAST_CYC), .HOLD_CYC(50)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_power_on(rx_power_on),
		.batch_tick(batch_tick));
	pws_tx_model i_tx (.pclk(pclk), .presetn(presetn), .sync(sync), .batch_tick(batch_tick), .pos(pos));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// A hang counts against the run instead of stalling it
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Model follows the same restart so positions stay comparable
	task automatic resync();
		apb(1'b1, 12'h010, 32'h00000008);
		sync <= 1'b1;
		@(posedge pclk);
		sync <= 1'b0;
	endtask : resync
	task automatic t_reset();
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h00001F20);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h00000000);
		apb(1'b1, 12'h004, 32'hFFFFFFFF);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0003FFFF);
		apb(1'b0, 12'h018, 32'h0);
		chk({rd[30:0], er}, 32'h00000001);
		$display("reset test done");
	endtask : t_reset
	task automatic t_events();
		logic [11:0] ea [5];
		logic [31:0] ev [5];
		logic        stay [5];
		int          n;
		ea = '{12'h010, 12'h010, 12'h010, 12'h014, 12'h014};
		ev = '{32'h1, 32'h4, 32'h2, 32'h0003FFFF, 32'h00000010};
		stay = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		resync();
		apb(1'b1, 12'h000, 32'h02021E00);
		for (int i = 0; i < 5; i++) begin
			n = 0;
			while (rx_power_on !== 1'b1 && n < 800) begin
				@(posedge pclk);
				n++;
			end
			chk(32'(n < 800), 32'h1);
			if (i == 0) begin
				apb(1'b0, 12'h008, 32'h0);
				chk(rd, 32'h00020100);
				chk(rd, {12'h000, pos.batch, 5'h00, pos.subseq, 2'h0, pos.cycle});
			end
			apb(1'b1, ea[i], ev[i]);
			repeat (stay[i] ? 40 : 2) @(posedge pclk);
			chk(32'(rx_power_on), 32'(stay[i]));
			repeat (20) @(posedge pclk);
			chk(32'(rx_power_on), 32'h0);
		end
		apb(1'b0, 12'h00C, 32'h0);
		chk({16'h0000, rd[31:16]}, 32'h00000005);
		$display("event test done");
	endtask : t_events
	task automatic t_wakes();
		logic [31:0] ctrl [5];
		int          ncyc [5];
		int          want [5];
		int          k;
		logic        last;
		ctrl = '{32'h02021F00, 32'h02020500, 32'h02021001, 32'h03020120, 32'h00021F00};
		ncyc = '{1, 1, 2, 4, 1};
		want = '{5, 2, 1, 1, 0};
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 12'h004, 32'h00000001);
			apb(1'b1, 12'h000, ctrl[i]);
			resync();
			k = 0;
			last = rx_power_on;
			repeat (ncyc[i] * CYCLE_CLK) begin
				@(posedge pclk);
				if (rx_power_on === 1'b1 && last !== 1'b1)
					k++;
				last = rx_power_on;
			end
			chk(32'(k), 32'(want[i]));
		end
		$display("wake count test done");
	endtask : t_wakes
	task automatic t_slots();
		int g;
		resync();
		for (int i = -1; i < 16; i++) begin
			g = 0;
			do begin
				@(posedge pclk);
				g++;
			end while (batch_tick !== 1'b1 && g < 100);
			if (i >= 0)
				chk(32'(g), 32'(i == 14 ? LAST_CYC : SHORT_CYC));
		end
		$display("slot length test done");
	endtask : t_slots
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		sync = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_events();
		t_slots();
		t_wakes();
		wrap_up();
	end
endmodule : pws_wake_scheduler_tb_top
`default_nettype wire
